// >>> verilog/fna_pkg.sv
// Functional notes
// - Seventeen instructions per reference period; the last halts and resets the address generator.
// - After halt, stay idle until the accumulator clock pulse restarts the sequence.
// - Datapath and pulse converter controls come from a read-only program lookup.
// - Each period, add the three fractional digits to the stored sum.
// - Total reaching or exceeding one drives divide select for N-1 division.
// - Least significant digit first; sum into top, top to middle, middle to bottom.
// - At period end bottom, middle, top hold low, mid and high digit sums.
// - Correction pulses come out in order: pulse three, pulse two, pulse one.
// - Pulse-width counter is reset on the prescaled edge after it reaches fifteen, ending the low pulse.
// - Counter is preset with the complement of the bottom register digit.
// - Counter advances on the prescaled oscillator, loop oscillator divided by ten.
// - Pulse lasts ten times (digit plus one) loop oscillator cycles.
// - Zero fraction keeps pulse widths constant; nonzero fraction changes them.
// - Track phase against the 100 kHz reference for divide select and pulses.
package fna_pkg;

  // Widths and sequencer shape
  localparam int unsigned DIGIT_W = 4;
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned NUM_CHAN = 3;
  localparam int unsigned SEQ_LEN = 17;
  localparam logic [ADDR_W-1:0] HALT_ADDR = 5'h10;
  localparam logic [DIGIT_W-1:0] CNT_MAX = 4'hF;
  localparam logic [DIGIT_W-1:0] BCD_MAX = 4'h9;
  localparam logic [DIGIT_W-1:0] BCD_ADJ = 4'h6;
  localparam logic [DIGIT_W-1:0] DIGIT_RST = 4'h0;

  // Timing: loop oscillator cycles per prescaled edge, clock cycles per reference period
  localparam int unsigned PSO_DIV = 10;
  localparam int unsigned REF_FREQ_KHZ = 100;
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned REF_PERIOD_NS = 1000000 / REF_FREQ_KHZ;
  localparam int unsigned REF_PERIOD_CYC = REF_PERIOD_NS / CLK_PERIOD_NS;

  // Digit selector codes
  localparam logic [1:0] DSEL_LOW = 2'h0;
  localparam logic [1:0] DSEL_MID = 2'h1;
  localparam logic [1:0] DSEL_HIGH = 2'h2;

  // Three fractional digits from the frequency-control source
  typedef struct packed {
    logic [DIGIT_W-1:0] frac_digit_high;
    logic [DIGIT_W-1:0] frac_digit_mid;
    logic [DIGIT_W-1:0] frac_digit_low;
  } fna_frac_type;

  // One instruction word of the sequencing state machine
  typedef struct packed {
    logic [1:0] dsel;
    logic add;
    logic clr;
    logic load;
    logic hold;
    logic rot;
    logic halt;
    logic [1:0] chan;
  } fna_ctrl_type;

  typedef enum logic {
    SEQ_IDLE,
    SEQ_RUN
  } fna_seq_type;

  // Program: clear carry, three adds, three pulse slots, three spares, halt
  localparam fna_ctrl_type PROGRAM [SEQ_LEN] = '{
    '{2'h0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 2'h0},
    '{DSEL_LOW, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 2'h0},
    '{DSEL_MID, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 2'h0},
    '{DSEL_HIGH, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 2'h0},
    '{2'h0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 2'h2},
    '{2'h0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 2'h2},
    '{2'h0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 2'h0},
    '{2'h0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 2'h1},
    '{2'h0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 2'h1},
    '{2'h0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 2'h0},
    '{2'h0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 2'h0},
    '{2'h0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 2'h0},
    '{2'h0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 2'h0},
    '{2'h0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 2'h0},
    '{2'h0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 2'h0},
    '{2'h0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 2'h0},
    '{2'h0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 2'h0}
  };

endpackage

// >>> verilog/fna_bcd_adder.sv
`timescale 1ns/1ps
module fna_bcd_adder
  import fna_pkg::*;
(
  input wire logic [DIGIT_W-1:0] a_i,
  input wire logic [DIGIT_W-1:0] b_i,
  input wire logic carry_i,
  output logic [DIGIT_W-1:0] sum_o,
  output logic carry_o
);

  logic [DIGIT_W:0] raw;
  logic [DIGIT_W:0] adj;

  // Binary sum, then the decimal correction when it passes nine
  always_comb begin
    raw = {1'b0, a_i} + {1'b0, b_i} + {{DIGIT_W{1'b0}}, carry_i};
    adj = raw + {1'b0, BCD_ADJ};
    if (raw > {1'b0, BCD_MAX}) begin
      sum_o = adj[DIGIT_W-1:0];
      carry_o = 1'b1;
    end else begin
      sum_o = raw[DIGIT_W-1:0];
      carry_o = 1'b0;
    end
  end

endmodule

// >>> verilog/fna_accumulator.sv
`timescale 1ns/1ps
module fna_accumulator
  import fna_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic acc_clock_i,
  input wire logic prescaled_osc_clock_i,
  input wire fna_frac_type frac_digits_i,
  output logic divide_select_out_o,
  output logic [NUM_CHAN-1:0] corr_pulse_b_o,
  output logic seq_busy_o
);

  // Pin synchronisers; the first stage feeds only the second
  logic acc_meta_q;
  logic acc_sync_q;
  logic acc_prev_q;
  logic pso_meta_q;
  logic pso_sync_q;
  logic pso_prev_q;
  fna_frac_type dig_meta_q;
  fna_frac_type dig_sync_q;
  logic acc_edge;
  logic pso_edge;

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      acc_meta_q <= 1'b0;
      acc_sync_q <= 1'b0;
      acc_prev_q <= 1'b0;
      pso_meta_q <= 1'b0;
      pso_sync_q <= 1'b0;
      pso_prev_q <= 1'b0;
      dig_meta_q <= '0;
      dig_sync_q <= '0;
    end else begin
      acc_meta_q <= acc_clock_i;
      acc_sync_q <= acc_meta_q;
      acc_prev_q <= acc_sync_q;
      pso_meta_q <= prescaled_osc_clock_i;
      pso_sync_q <= pso_meta_q;
      pso_prev_q <= pso_sync_q;
      dig_meta_q <= frac_digits_i;
      dig_sync_q <= dig_meta_q;
    end
  end

  // Rising edges of the accumulator clock and prescaled oscillator
  assign acc_edge = acc_sync_q & ~acc_prev_q;
  assign pso_edge = pso_sync_q & ~pso_prev_q;

  // Sequencer state
  fna_seq_type state_q;
  fna_seq_type state_d;
  logic [ADDR_W-1:0] addr_q;
  logic [ADDR_W-1:0] addr_d;
  fna_ctrl_type ctrl;
  logic exec;
  logic active_q;
  logic active_d;

  // Instruction fetched from the fixed program
  assign ctrl = PROGRAM[addr_q];
  assign exec = (state_q == SEQ_RUN);

  // Address generator: a load waits for a prescaled edge so the pulse
  // starts aligned; a hold waits for the pulse to finish. An accumulator
  // clock arriving while running is ignored, so the sequence must fit
  // inside one reference period.
  always_comb begin
    state_d = state_q;
    addr_d = addr_q;
    case (state_q)
      SEQ_IDLE: begin
        if (acc_edge) begin
          state_d = SEQ_RUN;
          addr_d = '0;
        end
      end
      SEQ_RUN: begin
        if (ctrl.halt) begin
          state_d = SEQ_IDLE;
          addr_d = '0;
        end else if (ctrl.load && !pso_edge) begin
          addr_d = addr_q;
        end else if (ctrl.hold && active_q) begin
          addr_d = addr_q;
        end else begin
          addr_d = addr_q + 5'h01;
        end
      end
      default: begin
        state_d = SEQ_IDLE;
        addr_d = '0;
      end
    endcase
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_q <= SEQ_IDLE;
      addr_q <= '0;
    end else begin
      state_q <= state_d;
      addr_q <= addr_d;
    end
  end

  // Summing datapath
  logic [DIGIT_W-1:0] top_sum_register_q;
  logic [DIGIT_W-1:0] top_sum_register_d;
  logic [DIGIT_W-1:0] middle_sum_register_q;
  logic [DIGIT_W-1:0] middle_sum_register_d;
  logic [DIGIT_W-1:0] bottom_sum_register_q;
  logic [DIGIT_W-1:0] bottom_sum_register_d;
  logic carry_q;
  logic carry_d;
  logic div_q;
  logic div_d;
  logic [DIGIT_W-1:0] sel_digit;
  logic [DIGIT_W-1:0] add_sum;
  logic add_carry;

  // Input multiplexer, low digit first in the program
  always_comb begin
    case (ctrl.dsel)
      DSEL_LOW: sel_digit = dig_sync_q.frac_digit_low;
      DSEL_MID: sel_digit = dig_sync_q.frac_digit_mid;
      DSEL_HIGH: sel_digit = dig_sync_q.frac_digit_high;
      default: sel_digit = DIGIT_RST;
    endcase
  end

  fna_bcd_adder u_adder (
    .a_i(sel_digit),
    .b_i(bottom_sum_register_q),
    .carry_i(carry_q),
    .sum_o(add_sum),
    .carry_o(add_carry)
  );

  // Add shifts right; rotate shifts right with bottom wrapping to top,
  // so three rotations restore the order left by the adds
  always_comb begin
    top_sum_register_d = top_sum_register_q;
    middle_sum_register_d = middle_sum_register_q;
    bottom_sum_register_d = bottom_sum_register_q;
    carry_d = carry_q;
    div_d = div_q;
    if (exec && ctrl.clr) begin
      carry_d = 1'b0;
    end
    if (exec && ctrl.add) begin
      top_sum_register_d = add_sum;
      middle_sum_register_d = top_sum_register_q;
      bottom_sum_register_d = middle_sum_register_q;
      carry_d = add_carry;
      if (ctrl.dsel == DSEL_HIGH) begin
        div_d = add_carry;
      end
    end
    if (exec && ctrl.rot) begin
      top_sum_register_d = bottom_sum_register_q;
      middle_sum_register_d = top_sum_register_q;
      bottom_sum_register_d = middle_sum_register_q;
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      top_sum_register_q <= DIGIT_RST;
      middle_sum_register_q <= DIGIT_RST;
      bottom_sum_register_q <= DIGIT_RST;
      carry_q <= 1'b0;
      div_q <= 1'b0;
    end else begin
      top_sum_register_q <= top_sum_register_d;
      middle_sum_register_q <= middle_sum_register_d;
      bottom_sum_register_q <= bottom_sum_register_d;
      carry_q <= carry_d;
      div_q <= div_d;
    end
  end

  // Digit to pulse converter
  logic [DIGIT_W-1:0] cnt_q;
  logic [DIGIT_W-1:0] cnt_d;
  logic [1:0] chan_q;
  logic [1:0] chan_d;
  logic [NUM_CHAN-1:0] corr_b_q;
  logic [NUM_CHAN-1:0] corr_b_d;
  logic busy_q;

  // Preset with the complement, count prescaled edges, stop past fifteen
  always_comb begin
    cnt_d = cnt_q;
    active_d = active_q;
    chan_d = chan_q;
    if (exec && ctrl.load && pso_edge) begin
      cnt_d = ~bottom_sum_register_q;
      active_d = 1'b1;
      chan_d = ctrl.chan;
    end else if (active_q && pso_edge) begin
      if (cnt_q == CNT_MAX) begin
        cnt_d = '0;
        active_d = 1'b0;
      end else begin
        cnt_d = cnt_q + 4'h1;
      end
    end
  end

  // Per-channel low-going pulse, registered so outputs never glitch
  for (genvar g = 0; g < NUM_CHAN; g++) begin : g_corr
    assign corr_b_d[g] = ~(active_d && (chan_d == 2'(g)));
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_q <= '0;
      active_q <= 1'b0;
      chan_q <= 2'h0;
      corr_b_q <= '1;
      busy_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      active_q <= active_d;
      chan_q <= chan_d;
      corr_b_q <= corr_b_d;
      busy_q <= (state_d == SEQ_RUN);
    end
  end

  assign divide_select_out_o = div_q;
  assign corr_pulse_b_o = corr_b_q;
  assign seq_busy_o = busy_q;

  // Checking helpers: pulse width in prescaled edges and period snapshot
  logic [DIGIT_W:0] width_q;
  logic [DIGIT_W-1:0] wdig_q;
  logic [3*DIGIT_W-1:0] snap_q;

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      width_q <= '0;
      wdig_q <= DIGIT_RST;
      snap_q <= '0;
    end else begin
      if (exec && ctrl.load && pso_edge) begin
        width_q <= '0;
        wdig_q <= bottom_sum_register_q;
      end else if (active_q && pso_edge) begin
        width_q <= width_q + 5'h01;
      end
      if (exec && ctrl.add && ctrl.dsel == DSEL_HIGH) begin
        snap_q <= {add_sum, top_sum_register_q, middle_sum_register_q};
      end
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);

  property p_halt_idles;
    exec && ctrl.halt |=> state_q == SEQ_IDLE && addr_q == '0;
  endproperty
  a_halt_idles: assert property (p_halt_idles) else $error("halt did not idle the sequencer");

  property p_restart;
    state_q == SEQ_IDLE && acc_edge |=> exec && addr_q == '0 ##1 addr_q == 5'h01;
  endproperty
  a_restart: assert property (p_restart) else $error("accumulator clock did not restart");

  property p_idle_hold;
    state_q == SEQ_IDLE && !acc_edge |=> state_q == SEQ_IDLE && $stable(addr_q);
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("sequencer left idle without clock");

  property p_shift;
    exec && ctrl.add |=> middle_sum_register_q == $past(top_sum_register_q)
      && bottom_sum_register_q == $past(middle_sum_register_q);
  endproperty
  a_shift: assert property (p_shift) else $error("add step did not shift registers");

  property p_divide;
    exec && ctrl.add && ctrl.dsel == DSEL_HIGH |=> divide_select_out_o == $past(add_carry);
  endproperty
  a_divide: assert property (p_divide) else $error("divide select mismatches top carry");

  property p_restore;
    exec && ctrl.halt |-> {top_sum_register_q, middle_sum_register_q, bottom_sum_register_q} == snap_q;
  endproperty
  a_restore: assert property (p_restore) else $error("sums not in place at period end");

  property p_order;
    $fell(corr_pulse_b_o[1]) |-> $past(addr_q, 2) == 5'h07 && corr_pulse_b_o[2];
  endproperty
  a_order: assert property (p_order) else $error("pulse two out of order");

  property p_preset;
    exec && ctrl.load && pso_edge |=> cnt_q == ~$past(bottom_sum_register_q);
  endproperty
  a_preset: assert property (p_preset) else $error("counter not preset with complement");

  property p_terminal;
    active_q && pso_edge && cnt_q == CNT_MAX |=> !active_q ##1 corr_pulse_b_o == '1;
  endproperty
  a_terminal: assert property (p_terminal) else $error("count of fifteen did not end pulse");

  property p_width;
    $fell(active_q) |-> width_q == {1'b0, wdig_q} + 5'h01;
  endproperty
  a_width: assert property (p_width) else $error("pulse width not digit plus one");

  c_full_period: cover property (exec && ctrl.halt);
  c_divide: cover property ($rose(divide_select_out_o));
  c_pulse_one: cover property ($rose(corr_pulse_b_o[0]));
  c_long_pulse: cover property ($fell(active_q) && wdig_q == BCD_MAX);

endmodule

// >>> tb/fna_loop_model.sv
`timescale 1ns/1ps
module fna_loop_model
  import fna_pkg::*;
#(
  parameter int PSO_HALF = 3
)
(
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic clear_i,
  input wire logic [NUM_CHAN-1:0] corr_pulse_b_i,
  output logic prescaled_osc_clock_o,
  output int width_o [NUM_CHAN],
  output int order_o
);
  int div_q;
  int cnt_q [NUM_CHAN];
  logic [NUM_CHAN-1:0] prev_q;

  // Oscillator divided down; it runs free like the real loop, so the sequence starts at any phase
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      div_q <= 0;
      prescaled_osc_clock_o <= 1'b0;
    end else if (div_q == PSO_HALF - 1) begin
      div_q <= 0;
      prescaled_osc_clock_o <= ~prescaled_osc_clock_o;
    end else begin
      div_q <= div_q + 1;
    end
  end

  // Phase detector side: width of each low pulse in clocks, and the order channels fell in
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      prev_q <= '1;
      order_o <= 0;
      for (int i = 0; i < NUM_CHAN; i++) begin
        cnt_q[i] <= 0;
        width_o[i] <= 0;
      end
    end else begin
      prev_q <= corr_pulse_b_i;
      for (int i = 0; i < NUM_CHAN; i++) begin
        if (!corr_pulse_b_i[i]) begin
          cnt_q[i] <= cnt_q[i] + 1;
        end else if (!prev_q[i]) begin
          width_o[i] <= cnt_q[i];
          cnt_q[i] <= 0;
        end
        if (prev_q[i] && !corr_pulse_b_i[i]) begin
          order_o <= order_o * 4 + i + 1;
        end
        if (clear_i) begin
          width_o[i] <= 0;
        end
      end
      if (clear_i) begin
        order_o <= 0;
      end
    end
  end
endmodule

// >>> tb/fractional_n_accumulator_tb.sv
`timescale 1ns/1ps
module fractional_n_accumulator_tb
  import fna_pkg::*;
;
  localparam int PSO_HALF = 3;
  localparam int PSO_P = 2 * PSO_HALF;
  localparam int LIMIT = 20000;
  logic clock_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic acc_clock_i = 1'b0;
  logic clear_q = 1'b1;
  fna_frac_type frac_q = '0;
  logic prescaled_osc_clock;
  logic div_sel;
  logic [NUM_CHAN-1:0] corr_b;
  logic busy;
  int width [NUM_CHAN];
  int order;
  int err_count = 0;
  int num_checks = 0;
  int cycles = 0;
  int s_lo = 0;
  int s_mid = 0;
  int s_hi = 0;
  logic exp_div = 1'b0;

  // Clock generator
  always #20 clock_i = ~clock_i;

  fna_accumulator dut (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .acc_clock_i(acc_clock_i),
    .prescaled_osc_clock_i(prescaled_osc_clock),
    .frac_digits_i(frac_q),
    .divide_select_out_o(div_sel),
    .corr_pulse_b_o(corr_b),
    .seq_busy_o(busy)
  );

  fna_loop_model #(.PSO_HALF(PSO_HALF)) far_end (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .clear_i(clear_q),
    .corr_pulse_b_i(corr_b),
    .prescaled_osc_clock_o(prescaled_osc_clock),
    .width_o(width),
    .order_o(order)
  );

  // Verdict and end of run
  task automatic conclude();
    $display("Checks %0d, mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Compare for signals of the design
  task automatic check_sig(input logic [3:0] got, input logic [3:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  // Compare for widths and orders measured by the far end
  task automatic check_num(input int got, input int exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  // Inputs always change one step after the rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask

  // Reference model of the decimal accumulator; carry in is cleared every period
  task automatic model_add(input int h, input int m, input int l);
    int t;
    t = s_lo + l;
    s_lo = t % 10;
    t = s_mid + m + t / 10;
    s_mid = t % 10;
    t = s_hi + h + t / 10;
    s_hi = t % 10;
    exp_div = (t >= 10);
  endtask

  // Reset, with outputs checked while it is held
  task automatic do_reset();
    rst_b_i = 1'b0;
    tick(3);
    check_sig(4'(div_sel), 4'h0);
    check_sig(4'(corr_b), 4'h7);
    check_sig(4'(busy), 4'h0);
    rst_b_i = 1'b1;
    s_lo = 0;
    s_mid = 0;
    s_hi = 0;
  endtask

  // Start the sequencer for one reference period; optionally a second edge arrives mid-run
  task automatic run_period(input int h, input int m, input int l, input bit poke);
    int n;
    frac_q.frac_digit_high = 4'(h);
    frac_q.frac_digit_mid = 4'(m);
    frac_q.frac_digit_low = 4'(l);
    clear_q = 1'b1;
    tick(4);
    clear_q = 1'b0;
    acc_clock_i = 1'b1;
    tick(4);
    acc_clock_i = 1'b0;
    n = 0;
    while (busy !== 1'b1 && n < 10) begin
      tick(1);
      n++;
    end
    check_sig(4'(busy), 4'h1);
    if (poke) begin
      tick(20);
      acc_clock_i = 1'b1;
      tick(4);
      acc_clock_i = 1'b0;
    end
    n = 0;
    while (busy !== 1'b0 && n < 600) begin
      tick(1);
      n++;
    end
    model_add(h, m, l);
    check_sig(4'(busy), 4'h0);
    check_sig(4'(div_sel), 4'(exp_div));
    check_num(width[2], (s_lo + 1) * PSO_P);
    check_num(width[1], (s_mid + 1) * PSO_P);
    check_num(width[0], (s_hi + 1) * PSO_P);
    check_num(order, 57);
    if (poke) begin
      tick(12);
      check_sig(4'(busy), 4'h0);
    end
  endtask

  // Zero fraction: widths stay at the shortest value period after period
  task automatic t_zero();
    run_period(0, 0, 0, 1'b0);
    run_period(0, 0, 0, 1'b0);
  endtask

  // Fraction 0.207 over five periods: the fifth crosses one; a stray edge is ignored
  task automatic t_example();
    for (int i = 0; i < 5; i++) begin
      run_period(2, 0, 7, i == 1);
    end
  endtask

  // Reset in mid-pulse, then all-nines plus one ripples a carry through every digit
  task automatic t_carry();
    int n;
    frac_q = '1;
    acc_clock_i = 1'b1;
    tick(4);
    acc_clock_i = 1'b0;
    n = 0;
    while (corr_b === 3'h7 && n < 100) begin
      tick(1);
      n++;
    end
    do_reset();
    tick(2);
    run_period(9, 9, 9, 1'b0);
    run_period(0, 0, 1, 1'b0);
  endtask

  // Hang guard
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == LIMIT) begin
      err_count++;
      conclude();
    end
  end

  // Main sequence
  initial begin
    do_reset();
    tick(2);
    t_zero();
    t_example();
    t_carry();
    conclude();
  end
endmodule
